// *** design/snf_pkg.sv ***
// Package of constants for the serial flash feature register bank.
// Assumes a single-bit serial link sampled by the 125 MHz system clock.
package snf_pkg;

  // ****
  // Command codes
  // ****
  localparam logic [7:0] CMD_SET_FEATURE = 8'h1F;
  localparam logic [7:0] CMD_GET_FEATURE = 8'h0F;
  localparam logic [7:0] CMD_WR_ENABLE   = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE  = 8'h04;
  localparam logic [7:0] CMD_RESET_A     = 8'hFF;
  localparam logic [7:0] CMD_RESET_B     = 8'hFE;

  // ****
  // Feature addresses
  // ****
  localparam logic [7:0] ADDR_THRESHOLD  = 8'h10;
  localparam logic [7:0] ADDR_FLIP_COUNT = 8'h20;
  localparam logic [7:0] ADDR_MAX_SECTOR = 8'h30;
  localparam logic [7:0] ADDR_MAP_LOW    = 8'h40;
  localparam logic [7:0] ADDR_MAP_HIGH   = 8'h50;
  localparam logic [7:0] ADDR_LOCK       = 8'hA0;
  localparam logic [7:0] ADDR_CONFIG     = 8'hB0;
  localparam logic [7:0] ADDR_STATUS     = 8'hC0;

  // ****
  // Field positions
  // ****
  localparam int LOCK_GUARD_BIT   = 7;
  localparam int LOCK_RANGE_LSB   = 3;
  localparam int CFG_PROTECT_BIT  = 7;
  localparam int CFG_ID_READ_BIT  = 6;
  localparam int CFG_ECC_EN_BIT   = 4;
  localparam int CFG_BBI_BIT      = 2;
  localparam int CFG_FAST_BIT     = 1;
  localparam int STS_ECC_LSB      = 4;
  localparam int STS_PROG_FAIL    = 3;
  localparam int STS_ERASE_FAIL   = 2;
  localparam int STS_WEL_BIT      = 1;
  localparam int STS_BUSY_BIT     = 0;
  localparam int THR_FIELD_LSB    = 4;

  // ****
  // Writable masks and power-on values
  // ****
  localparam logic [7:0] LOCK_WR_MASK    = 8'hB8;
  localparam logic [7:0] CONFIG_WR_MASK  = 8'hD2;
  localparam logic [7:0] THRESH_WR_MASK  = 8'hF0;
  localparam logic [7:0] LOCK_RESET      = 8'h38;
  localparam logic [7:0] CONFIG_RESET    = 8'h16;
  localparam logic [7:0] THRESH_RESET    = 8'h00;

  // ****
  // ECC status codes
  // ****
  localparam logic [1:0] ECC_CLEAN       = 2'h0;
  localparam logic [1:0] ECC_FIXED_LOW   = 2'h1;
  localparam logic [1:0] ECC_UNFIXABLE   = 2'h2;
  localparam logic [1:0] ECC_FIXED_HIGH  = 2'h3;

  // ****
  // Link framing
  // ****
  localparam int BYTE_BITS = 8;

endpackage

// *** design/snf_sync.sv ***
// Two-stage synchroniser for pins that enter the system clock domain.
// Assumes the caller holds its clock enable with the rest of the block.
`timescale 1ns/10ps
`default_nettype none

module snf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,  // System clock.
  input  wire logic             rst_i,      // Synchronous reset, high.
  input  wire logic             clk_en_i,   // Freezes state while low.
  input  wire logic [WIDTH-1:0] async_i,    // Pin levels.
  output logic      [WIDTH-1:0] sync_o      // Synchronised levels.
);

  logic [WIDTH-1:0] stage1_reg;

  // ****
  // Two flops; the first is read only by the second.
  // ****
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage1_reg <= '0;
      sync_o     <= '0;
    end else if (clk_en_i) begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end

endmodule // snf_sync

`default_nettype wire

// *** design/snf_feature_bank.sv ***
// Feature register bank of a serial NAND flash, behind its serial pins.
// Assumes link pins from another clock domain and live status from the
// array engines on the system clock.
//
// Behaviour
// [R1] Write-feature 1Fh stores a byte; read-feature 0Fh returns one.
// [R2] Written features survive both reset commands, lost only at power-on.
// [R3] Write-enable latch ignores feature writes; 06h sets, 04h clears.
// [R4] Reserved bits always read back as zero.
// [R5] Host addresses only defined feature registers.
// [R6] ECC fields are meaningful only while the ECC enable bit is set.
// [R7] Power-on restores every feature bit to its default.
// [R8] Guard bit set with protect pin low blocks guard and range writes.
// [R9] Lock range field bits 5:3, 000 unlocked to 111 all locked.
// [R10] Protect enable bit 7 of config lets the protect command through.
// [R11] ID-read enable bit 6 selects parameter page and unique-ID mode.
// [R12] ECC enable bit 4 defaults to one; zero disables correction.
// [R13] Bad-block inhibit bit 2 is read-only and reads one.
// [R14] Fast page read bit 1 is writable and defaults to one.
// [R15] ECC status bits 5:4 report the previous page read result.
// [R16] Corrected-status threshold comes from threshold register bits 7:4.
// [R17] Program-fail bit 3 reports the last program or protect result.
// [R18] Erase-fail bit 2 reports the last erase result.
// [R19] Write-enable latch bit 1 reads one when enabled, defaults zero.
// [R20] Busy bit 0 reads one during any internal operation.
// [R21] Read-feature keeps shifting the selected byte out repeatedly.
// [R22] Each repeated byte carries live busy and fail bits.
// [R23] Repetition continues until chip select rises.
// [R24] Host sends only 0Fh or resets while busy.
// [R25] Write: command, address, data, MSB first, committed at select rise.
`timescale 1ns/10ps
`default_nettype none

module snf_feature_bank (
  input  wire logic       sys_clk_i,       // System clock, 125 MHz.
  input  wire logic       rst_i,           // Power-on reset, high.
  input  wire logic       clk_en_i,        // Freezes all state while low.
  input  wire logic       sck_i,           // Serial clock pin.
  input  wire logic       cs_n_i,          // Chip select pin, low active.
  input  wire logic       si_i,            // Serial data in pin.
  input  wire logic       wp_n_i,          // Write-protect pin, low active.
  input  wire logic       busy_i,          // Array engine operating.
  input  wire logic       prog_fail_i,     // Last program or protect failed.
  input  wire logic       erase_fail_i,    // Last erase failed.
  input  wire logic       ecc_done_i,      // Pulse: page read result valid.
  input  wire logic       ecc_uncorr_i,    // Page read was uncorrectable.
  input  wire logic [3:0] ecc_flips_i,     // Flips corrected in that read.
  input  wire logic [7:0] flip_count_i,    // Flip count report byte.
  input  wire logic [7:0] max_sector_i,    // Max flip sector byte.
  input  wire logic [7:0] map_low_i,       // Flip sector map, low byte.
  input  wire logic [7:0] map_high_i,      // Flip sector map, high byte.
  output logic            so_o,            // Serial data out pin level.
  output logic            so_oe_o,         // Drive enable for serial out.
  output logic [2:0]      lock_range_o,    // Lock range setting.
  output logic            protect_cmd_enable_o, // Protect command allowed.
  output logic            id_page_read_enable_o,// ID read mode.
  output logic            ecc_enable_o,    // Internal correction enabled.
  output logic            fast_page_read_enable_o, // Fast page read.
  output logic            write_enable_latch_o,    // Write enable latch.
  output logic            reset_cmd_o      // Pulse: reset command seen.
);

  typedef enum logic [1:0] {SNF_CMD, SNF_ADDR, SNF_DATA, SNF_IDLE} snf_phase_t;

  // ****
  // Pin synchronisation
  // ****
  // Low-active pins are carried inverted so that the zero reset of the
  // synchroniser reads as deselected and unprotected, with no false edge.
  logic [3:0] pins_sync;
  snf_sync #(.WIDTH(4)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .async_i   ({sck_i, ~cs_n_i, si_i, ~wp_n_i}),
    .sync_o    (pins_sync)
  );

  wire sck_s  = pins_sync[3];
  wire cs_n_s = ~pins_sync[2];
  wire si_s   = pins_sync[1];
  wire wp_n_s = ~pins_sync[0];

  // ****************************************************************
  // State
  // ****************************************************************
  snf_phase_t phase_reg;
  logic       sck_d_reg;
  logic       cs_n_d_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_reg;
  logic [7:0] data_reg;
  logic       data_full_reg;
  logic [7:0] out_byte_reg;
  logic [7:0] lock_reg;
  logic [7:0] config_reg;
  logic [7:0] thresh_reg;
  logic       wel_reg;
  logic [1:0] ecc_sts_reg;

  // ****************************************************************
  // Edge and framing decode
  // ****************************************************************
  wire sck_rise  = sck_s & ~sck_d_reg;
  wire sck_fall  = ~sck_s & sck_d_reg;
  wire cs_active = ~cs_n_s;
  wire cs_rise   = cs_n_s & ~cs_n_d_reg;
  wire cs_fall   = ~cs_n_s & cs_n_d_reg;
  wire [7:0] byte_in   = {shift_reg[6:0], si_s};
  wire       byte_done = cs_active & sck_rise & (bit_cnt_reg == 3'h7);

  // A write only commits when the full data byte arrived. [R25]
  wire do_write   = cs_rise & (cmd_reg == snf_pkg::CMD_SET_FEATURE) & data_full_reg; // [R1]
  wire is_get     = (cmd_reg == snf_pkg::CMD_GET_FEATURE);
  wire wel_set    = cs_rise & (cmd_reg == snf_pkg::CMD_WR_ENABLE)  & (phase_reg == SNF_ADDR); // [R3]
  wire wel_clear  = cs_rise & (cmd_reg == snf_pkg::CMD_WR_DISABLE) & (phase_reg == SNF_ADDR); // [R3]
  wire reset_seen = cs_rise & (phase_reg == SNF_ADDR) &
                    ((cmd_reg == snf_pkg::CMD_RESET_A) | (cmd_reg == snf_pkg::CMD_RESET_B));

  // Guard bit with the protect pin low freezes guard and range. [R8]
  wire lock_frozen = lock_reg[snf_pkg::LOCK_GUARD_BIT] & ~wp_n_s;

  // ****************************************************************
  // Write data merge
  // ****************************************************************
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  wire [7:0] lock_next   = merge(lock_reg, data_reg, snf_pkg::LOCK_WR_MASK);       // [R9] [R4]
  wire [7:0] config_next = merge(config_reg, data_reg, snf_pkg::CONFIG_WR_MASK);   // [R10] [R11] [R12] [R14]
  wire [7:0] thresh_next = merge(thresh_reg, data_reg, snf_pkg::THRESH_WR_MASK);   // [R16] [R4]

  // ****************************************************************
  // ECC result classification
  // ****************************************************************
  wire [3:0] thresh_field = thresh_reg[snf_pkg::THR_FIELD_LSB +: 4]; // [R16]
  wire [1:0] ecc_class =
    ecc_uncorr_i                  ? snf_pkg::ECC_UNFIXABLE  :
    (ecc_flips_i == 4'h0)         ? snf_pkg::ECC_CLEAN      :
    (ecc_flips_i >= thresh_field) ? snf_pkg::ECC_FIXED_HIGH :
                                    snf_pkg::ECC_FIXED_LOW;   // [R15]

  // ECC fields read zero while correction is off. [R6]
  wire ecc_on = config_reg[snf_pkg::CFG_ECC_EN_BIT];

  // Status byte is built live from the engine inputs. [R17] [R18] [R20]
  wire [7:0] status_live = {2'h0,
                            ecc_on ? ecc_sts_reg : 2'h0,
                            prog_fail_i, erase_fail_i, wel_reg, busy_i}; // [R19] [R4]

  // ****************************************************************
  // Read mux; unmapped addresses answer zero.
  // ****************************************************************
  logic [7:0] read_mux;
  always_comb begin
    case (addr_reg)
      snf_pkg::ADDR_THRESHOLD:  read_mux = ecc_on ? thresh_reg : 8'h00; // [R6]
      snf_pkg::ADDR_FLIP_COUNT: read_mux = ecc_on ? {4'h0, flip_count_i[3:0]} : 8'h00;
      snf_pkg::ADDR_MAX_SECTOR: read_mux = ecc_on ? {max_sector_i[7:4], 1'b0, max_sector_i[2:0]} : 8'h00;
      snf_pkg::ADDR_MAP_LOW:    read_mux = ecc_on ? map_low_i : 8'h00;
      snf_pkg::ADDR_MAP_HIGH:   read_mux = ecc_on ? map_high_i : 8'h00;
      snf_pkg::ADDR_LOCK:       read_mux = lock_reg;
      snf_pkg::ADDR_CONFIG:     read_mux = config_reg;  // [R13]
      snf_pkg::ADDR_STATUS:     read_mux = status_live; // [R22]
      default:                  read_mux = 8'h00;       // [R5]
    endcase
  end

  // ****************************************************************
  // Edge trackers
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sck_d_reg  <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else if (clk_en_i) begin
      sck_d_reg  <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // ****************************************************************
  // Input shifter, MSB first. [R25]
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
    end else if (clk_en_i) begin
      if (!cs_active) begin
        bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        shift_reg   <= byte_in;
      end
    end
  end

  // ****************************************************************
  // Byte phase sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase_reg     <= SNF_IDLE;
      cmd_reg       <= 8'h00;
      addr_reg      <= 8'h00;
      data_reg      <= 8'h00;
      data_full_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (cs_fall) begin
        phase_reg     <= SNF_CMD;
        data_full_reg <= 1'b0;
        cmd_reg       <= 8'h00;
      end else if (byte_done) begin
        case (phase_reg)
          SNF_CMD: begin
            cmd_reg   <= byte_in;
            phase_reg <= SNF_ADDR;
          end
          SNF_ADDR: begin
            addr_reg  <= byte_in;
            phase_reg <= SNF_DATA;
          end
          SNF_DATA: begin
            if (!data_full_reg) begin
              data_reg      <= byte_in;
              data_full_reg <= 1'b1;
            end
          end
          default: begin
            phase_reg <= SNF_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Feature registers; only rst_i models power-on, so reset commands
  // leave them alone. [R2] [R7]
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lock_reg   <= snf_pkg::LOCK_RESET;   // [R9]
      config_reg <= snf_pkg::CONFIG_RESET; // [R12] [R13] [R14]
      thresh_reg <= snf_pkg::THRESH_RESET;
    end else if (clk_en_i && do_write) begin
      if (addr_reg == snf_pkg::ADDR_LOCK && !lock_frozen) begin
        lock_reg <= lock_next; // [R8]
      end
      if (addr_reg == snf_pkg::ADDR_CONFIG) begin
        config_reg <= config_next;
      end
      if (addr_reg == snf_pkg::ADDR_THRESHOLD) begin
        thresh_reg <= thresh_next;
      end
    end
  end

  // ****************************************************************
  // Write-enable latch and ECC result capture.
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wel_reg     <= 1'b0; // [R19]
      ecc_sts_reg <= snf_pkg::ECC_CLEAN;
    end else if (clk_en_i) begin
      if (wel_set) begin
        wel_reg <= 1'b1; // [R3]
      end else if (wel_clear) begin
        wel_reg <= 1'b0;
      end
      if (ecc_done_i) begin
        ecc_sts_reg <= ecc_class; // [R15]
      end
    end
  end

  // ****************************************************************
  // Output shifter. The byte reloads at every boundary so live status
  // bits refresh; the host samples on the rising edge, so data
  // changes on falling edges. [R21] [R22] [R23]
  // ****************************************************************
  wire get_active = cs_active & is_get & (phase_reg == SNF_DATA);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_byte_reg <= 8'h00;
      so_o         <= 1'b0;
      so_oe_o      <= 1'b0;
    end else if (clk_en_i) begin
      if (!get_active) begin
        so_oe_o <= 1'b0; // [R23]
        out_byte_reg <= read_mux;
      end else if (sck_fall) begin
        so_oe_o <= 1'b1;
        if (bit_cnt_reg == 3'h0) begin
          so_o         <= read_mux[7];
          out_byte_reg <= {read_mux[6:0], 1'b0};
        end else begin
          so_o         <= out_byte_reg[7];
          out_byte_reg <= {out_byte_reg[6:0], 1'b0};
        end
      end
    end
  end

  // ****************************************************************
  // Registered control outputs.
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lock_range_o            <= snf_pkg::LOCK_RESET[5:3];
      protect_cmd_enable_o    <= 1'b0;
      id_page_read_enable_o   <= 1'b0;
      ecc_enable_o            <= 1'b1;
      fast_page_read_enable_o <= 1'b1;
      write_enable_latch_o    <= 1'b0;
      reset_cmd_o             <= 1'b0;
    end else if (clk_en_i) begin
      lock_range_o            <= lock_reg[snf_pkg::LOCK_RANGE_LSB +: 3];
      protect_cmd_enable_o    <= config_reg[snf_pkg::CFG_PROTECT_BIT]; // [R10]
      id_page_read_enable_o   <= config_reg[snf_pkg::CFG_ID_READ_BIT]; // [R11]
      ecc_enable_o            <= ecc_on;
      fast_page_read_enable_o <= config_reg[snf_pkg::CFG_FAST_BIT];
      write_enable_latch_o    <= wel_reg;
      reset_cmd_o             <= reset_seen;
    end
  end

endmodule // snf_feature_bank

`default_nettype wire

// *** testbench/snf_feature_bank_asserts.sv ***
// Checker for the feature bank: serial output framing, commit timing
// and reset command pulses. Assumes one clock domain, synchronous reset.
`timescale 1ns/10ps
`default_nettype none

module snf_feature_bank_chk (
  input wire logic       sys_clk_i,               // System clock.
  input wire logic       rst_i,                   // Reset, high.
  input wire logic       cs_n_i,                  // Chip select pin.
  input wire logic       so_oe_o,                 // Serial out enable.
  input wire logic [2:0] lock_range_o,            // Lock range.
  input wire logic       protect_cmd_enable_o,    // Protect enable.
  input wire logic       id_page_read_enable_o,   // ID read mode.
  input wire logic       ecc_enable_o,            // Correction enable.
  input wire logic       fast_page_read_enable_o, // Fast page read.
  input wire logic       write_enable_latch_o,    // Write enable latch.
  input wire logic       reset_cmd_o              // Reset command pulse.
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ****
  // Properties
  // ****
  // Settings gathered so one change test covers all of them.
  wire logic [7:0] cfg_bus = {lock_range_o, protect_cmd_enable_o, id_page_read_enable_o,
                              ecc_enable_o, fast_page_read_enable_o, 1'b0};
  property p_defaults;
    $fell(rst_i) |-> cfg_bus == 8'hE6 && !write_enable_latch_o && !so_oe_o;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad power-on values");
  // Output starts only while select is low and select was also low 100 clocks earlier.
  property p_oe_late;
    $rose(so_oe_o) |-> !cs_n_i && $past(cs_n_i, 100) == 1'b0;
  endproperty
  a_oe_late: assert property (p_oe_late) else $error("early output");
  property p_oe_hold;
    so_oe_o && !cs_n_i |=> so_oe_o;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("output stopped");
  property p_oe_drop;
    $rose(cs_n_i) |-> ##[1:6] !so_oe_o;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("output kept");
  property p_rst_pulse;
    reset_cmd_o |-> cs_n_i ##1 !reset_cmd_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("bad reset pulse");
  // A software reset must leave every setting alone.
  property p_rst_keep;
    reset_cmd_o |=> $stable(cfg_bus) [*4];
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("reset moved setting");
  property p_wel_cs;
    $changed(write_enable_latch_o) |-> cs_n_i && $past(cs_n_i);
  endproperty
  a_wel_cs: assert property (p_wel_cs) else $error("latch moved inside a frame");
  // Select pin rise is at least two clocks old when a setting output changes.
  property p_cfg_cs;
    $changed(cfg_bus) |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  a_cfg_cs: assert property (p_cfg_cs) else $error("early setting change");
endmodule // snf_feature_bank_chk

bind snf_feature_bank snf_feature_bank_chk snf_feature_bank_chk_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o), .lock_range_o(lock_range_o),
  .protect_cmd_enable_o(protect_cmd_enable_o), .id_page_read_enable_o(id_page_read_enable_o),
  .ecc_enable_o(ecc_enable_o), .fast_page_read_enable_o(fast_page_read_enable_o),
  .write_enable_latch_o(write_enable_latch_o), .reset_cmd_o(reset_cmd_o)
);
`default_nettype wire

// *** testbench/snf_host_model.sv ***
// Serial host model: sends frames MSB first and reads bits back.
// Assumes the device shifts on sck fall; the host samples on sck rise.
`timescale 1ns/10ps
`default_nettype none

module snf_host_model (
  input  wire logic sys_clk_i, // System clock, paces the link.
  input  wire logic so_i,      // Serial data from the device.
  output logic      sck_o,     // Serial clock, still between frames.
  output logic      cs_n_o,    // Chip select, low active.
  output logic      si_o       // Serial data to the device.
);
  logic [15:0] rx = 16'h0000;  // Bits read back, newest in bit 0.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Half of the 80 ns link period.
  task automatic half();
    repeat (5) @(posedge sys_clk_i);
  endtask
  // Frame of ntx bytes from the top of tx, then nrx bits read until select rises.
  task automatic frame(input logic [23:0] tx, input int ntx, input int nrx);
    cs_n_o <= 1'b0;
    half();
    for (int i = 0; i < ntx * 8; i++) begin
      sck_o <= 1'b0;
      si_o <= tx[23 - i];
      half();
      sck_o <= 1'b1;
      half();
    end
    for (int i = 0; i < nrx; i++) begin
      sck_o <= 1'b0;
      half();
      sck_o <= 1'b1;
      rx <= {rx[14:0], so_i};
      half();
    end
    sck_o <= 1'b0;
    half();
    // Released data line shows the inverse so stale values never pass.
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (2) half();
  endtask
endmodule // snf_host_model
`default_nettype wire

// *** testbench/snf_feature_bank_tb_top.sv ***
// Self-checking bench for the feature bank, driven through the host model.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/10ps
`default_nettype none

module snf_feature_bank_tb_top;
  // ****
  // Signals
  // ****
  logic       sys_clk = 1'b0, rst = 1'b1, wp_n = 1'b1, sck, cs_n, si, so, so_oe;
  logic       busy = 1'b0, prog_fail = 1'b0, erase_fail = 1'b0, ecc_done = 1'b0, ecc_uncorr = 1'b0;
  logic       protect, id_rd, ecc_en, fast, write_enable_latch;
  logic [3:0] ecc_flips = 4'h0;
  logic [2:0] lock_range;
  logic [7:0] flip_count = 8'hA5, max_sector = 8'hFF, map_low = 8'h3C, map_high = 8'hC3;
  int         n_fail = 0;
  int         check_count = 0;
  // Page read results (uncorrectable, flips) and the class expected at threshold 3.
  logic [4:0] ecc_in [4] = '{5'h00, 5'h02, 5'h03, 5'h15};
  logic [1:0] ecc_cls [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

  always #4 sys_clk = ~sys_clk;

  snf_feature_bank snf_feature_bank_inst (
    .sys_clk_i(sys_clk), .rst_i(rst), .clk_en_i(1'b1), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n),
    .busy_i(busy), .prog_fail_i(prog_fail), .erase_fail_i(erase_fail), .ecc_done_i(ecc_done),
    .ecc_uncorr_i(ecc_uncorr), .ecc_flips_i(ecc_flips), .flip_count_i(flip_count), .max_sector_i(max_sector),
    .map_low_i(map_low), .map_high_i(map_high), .so_o(so), .so_oe_o(so_oe), .lock_range_o(lock_range),
    .protect_cmd_enable_o(protect), .id_page_read_enable_o(id_rd), .ecc_enable_o(ecc_en),
    .fast_page_read_enable_o(fast), .write_enable_latch_o(write_enable_latch), .reset_cmd_o()
  );
  snf_host_model snf_host_model_inst (.sys_clk_i(sys_clk), .so_i(so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

  // ****
  // Access and report tasks
  // ****
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_feat(input logic [7:0] addr, input logic [7:0] dat);
    snf_host_model_inst.frame({snf_pkg::CMD_SET_FEATURE, addr, dat}, 3, 0);
  endtask
  task automatic cmd(input logic [7:0] code);
    snf_host_model_inst.frame({code, 16'h0000}, 1, 0);
  endtask
  // Two bytes are read so the repeated copy is compared too; only defined addresses are used.
  task automatic rd_feat(input logic [7:0] addr, input logic [7:0] exp);
    snf_host_model_inst.frame({snf_pkg::CMD_GET_FEATURE, addr, 8'h00}, 2, 16);
    chk("feature byte", snf_host_model_inst.rx[15:8], exp);
    chk("repeated byte", snf_host_model_inst.rx[7:0], exp);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd_feat(snf_pkg::ADDR_LOCK, 8'h38);
    rd_feat(snf_pkg::ADDR_CONFIG, 8'h16);
    rd_feat(snf_pkg::ADDR_STATUS, 8'h00);
    $display("Test defaults ended");
    wr_feat(snf_pkg::ADDR_CONFIG, 8'hFF);
    rd_feat(snf_pkg::ADDR_CONFIG, 8'hD6);
    chk("config outputs", {4'h0, protect, id_rd, ecc_en, fast}, 8'h0F);
    wr_feat(snf_pkg::ADDR_CONFIG, 8'h00);
    chk("config outputs", {4'h0, protect, id_rd, ecc_en, fast}, 8'h00);
    rd_feat(snf_pkg::ADDR_FLIP_COUNT, 8'h00);
    wr_feat(snf_pkg::ADDR_CONFIG, 8'h10);
    rd_feat(snf_pkg::ADDR_FLIP_COUNT, 8'h05);
    rd_feat(snf_pkg::ADDR_MAX_SECTOR, 8'hF7);
    rd_feat(snf_pkg::ADDR_MAP_LOW, 8'h3C);
    rd_feat(snf_pkg::ADDR_MAP_HIGH, 8'hC3);
    $display("Test config ended");
    for (int i = 0; i < 8; i++) begin
      wr_feat(snf_pkg::ADDR_LOCK, 8'(i << 3));
      chk("lock range output", {5'h00, lock_range}, 8'(i));
    end
    wp_n <= 1'b0;
    wr_feat(snf_pkg::ADDR_LOCK, 8'hA8);
    wr_feat(snf_pkg::ADDR_LOCK, 8'h00);
    rd_feat(snf_pkg::ADDR_LOCK, 8'hA8);
    wp_n <= 1'b1;
    wr_feat(snf_pkg::ADDR_LOCK, 8'h00);
    rd_feat(snf_pkg::ADDR_LOCK, 8'h00);
    snf_host_model_inst.frame({snf_pkg::CMD_SET_FEATURE, snf_pkg::ADDR_LOCK, 8'h38}, 2, 0);
    rd_feat(snf_pkg::ADDR_LOCK, 8'h00);
    $display("Test lock ended");
    wr_feat(snf_pkg::ADDR_STATUS, 8'h02);
    rd_feat(snf_pkg::ADDR_STATUS, 8'h00);
    cmd(snf_pkg::CMD_WR_ENABLE);
    rd_feat(snf_pkg::ADDR_STATUS, 8'h02);
    wr_feat(snf_pkg::ADDR_STATUS, 8'h00);
    chk("latch output", {7'h00, write_enable_latch}, 8'h01);
    cmd(snf_pkg::CMD_WR_DISABLE);
    rd_feat(snf_pkg::ADDR_STATUS, 8'h00);
    prog_fail <= 1'b1;
    rd_feat(snf_pkg::ADDR_STATUS, 8'h08);
    prog_fail <= 1'b0;
    erase_fail <= 1'b1;
    rd_feat(snf_pkg::ADDR_STATUS, 8'h04);
    erase_fail <= 1'b0;
    // Busy rises during the first output byte and must show in the next one.
    fork
      snf_host_model_inst.frame({snf_pkg::CMD_GET_FEATURE, snf_pkg::ADDR_STATUS, 8'h00}, 2, 16);
      begin
        repeat (210) @(posedge sys_clk);
        busy <= 1'b1;
      end
    join
    chk("status before busy", snf_host_model_inst.rx[15:8], 8'h00);
    chk("status while busy", snf_host_model_inst.rx[7:0], 8'h01);
    busy <= 1'b0;
    $display("Test status ended");
    wr_feat(snf_pkg::ADDR_THRESHOLD, 8'h3F);
    rd_feat(snf_pkg::ADDR_THRESHOLD, 8'h30);
    for (int i = 0; i < 4; i++) begin
      ecc_uncorr <= ecc_in[i][4];
      ecc_flips <= ecc_in[i][3:0];
      ecc_done <= 1'b1;
      @(posedge sys_clk);
      ecc_done <= 1'b0;
      rd_feat(snf_pkg::ADDR_STATUS, {2'h0, ecc_cls[i], 4'h0});
    end
    wr_feat(snf_pkg::ADDR_LOCK, 8'h18);
    cmd(snf_pkg::CMD_RESET_A);
    cmd(snf_pkg::CMD_RESET_B);
    rd_feat(snf_pkg::ADDR_LOCK, 8'h18);
    rd_feat(snf_pkg::ADDR_THRESHOLD, 8'h30);
    rd_feat(snf_pkg::ADDR_CONFIG, 8'h14);
    wr_feat(snf_pkg::ADDR_CONFIG, 8'h00);
    rd_feat(snf_pkg::ADDR_STATUS, 8'h00);
    $display("Test ecc and reset ended");
    wrap_up();
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    $display("[FAIL] watchdog expected run end seen timeout");
    wrap_up();
  end
endmodule // snf_feature_bank_tb_top
`default_nettype wire
